//--- osc_pkg.sv
// Constants, register layouts and state types for the oscillator source control block.
// Assumes a single AHB-Lite slave with 32-bit data and byte addresses in haddr[7:0].
package osc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CLK_CTRL_OFF  = 8'h00;
	localparam logic [7:0] XTAL_CTRL_OFF = 8'h04;
	localparam logic [7:0] PIN_OFF       = 8'h08;
	localparam logic [7:0] SU_OFF        = 8'h0c;
	localparam logic [7:0] LP_OFF        = 8'h10;

	// ----------------------------------------------------------------
	// Field values and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0]  SEL_SLOW      = 3'h7;
	localparam logic        FAST_SRC_XTAL = 1'h0;
	localparam logic        SLOW_SRC_XTAL = 1'h1;
	localparam logic        MODE_LOWPOWER = 1'h0;
	localparam logic [7:0]  CLK_CTRL_RST  = 8'h00;
	localparam logic [1:0]  PIN_RST       = 2'h0;
	localparam logic [15:0] SU_CNT_RST    = 16'h0400;
	localparam logic [15:0] LP_CNT_RST    = 16'h4000;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] clk_sel;
		logic       rsv;
		logic       fast_src;
		logic       slow_src;
		logic       fast_idle_en;
		logic       slow_idle_en;
	} osc_clk_ctrl_s;

	typedef struct packed {
		logic [4:0] rsv;
		logic       speedup;
		logic       stable;
		logic       enable;
	} osc_xtal_ctrl_s;

	typedef enum logic [1:0] {XS_OFF, XS_START, XS_STABLE} osc_xstate_e;

endpackage : osc_pkg

//--- osc_ctrl.sv
// Oscillator source control: clock select, slow crystal start-up and pin sharing.
// Assumes slow_xtal_tick is a one-cycle pulse per slow crystal cycle, synchronous to hclk.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module osc_ctrl (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        halt_req,
	input  wire logic        wake_req,
	input  wire logic        slow_xtal_tick,
	output logic      [2:0]  sysclk_select_field,
	output logic             fast_source_sel,
	output logic             slow_source_sel,
	output logic             sys_clk_run,
	output logic             fast_osc_run,
	output logic             slow_osc_run,
	output logic             slow_crystal_enable,
	output logic             slow_crystal_speedup,
	output logic             slow_crystal_stable,
	output logic             slow_xtal_in_pin_osc,
	output logic             slow_xtal_out_pin_osc
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Every transfer takes one wait state, so a read always sees a write just before it.
	logic              pend_reg;
	logic              pend_write_reg;
	logic [7:0]        pend_addr_reg;
	logic [31:0]       hrdata_reg;
	logic              hreadyout_reg;
	logic              hresp_reg;
	logic              taken;
	logic              wr_clk_ctrl;
	logic              wr_xtal_ctrl;
	logic              wr_pin;
	logic              wr_su;
	logic              wr_lp;
	logic              rd_now;

	osc_pkg::osc_clk_ctrl_s  clk_ctrl_reg;
	osc_pkg::osc_xtal_ctrl_s xtal_ctrl_reg;
	osc_pkg::osc_clk_ctrl_s  clk_ctrl_next;
	osc_pkg::osc_xtal_ctrl_s xtal_ctrl_rd;
	logic [1:0]         pin_reg;
	logic [15:0]        su_cnt_reg;
	logic [15:0]        lp_cnt_reg;
	logic               stable_reg;
	logic               asleep_reg;
	logic               asleep_next;
	logic               locked;
	logic [15:0]        cnt_reg;
	logic [15:0]        limit;
	osc_pkg::osc_xstate_e xstate_reg;

	assign taken   = hsel && hready && (htrans == osc_pkg::HTRANS_NONSEQ) && hreadyout_reg;
	assign rd_now  = pend_reg && !pend_write_reg;
	assign wr_clk_ctrl  = pend_reg && pend_write_reg && (pend_addr_reg == osc_pkg::CLK_CTRL_OFF);
	assign wr_xtal_ctrl = pend_reg && pend_write_reg && (pend_addr_reg == osc_pkg::XTAL_CTRL_OFF);
	assign wr_pin  = pend_reg && pend_write_reg && (pend_addr_reg == osc_pkg::PIN_OFF);
	assign wr_su   = pend_reg && pend_write_reg && (pend_addr_reg == osc_pkg::SU_OFF);
	assign wr_lp   = pend_reg && pend_write_reg && (pend_addr_reg == osc_pkg::LP_OFF);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg       <= 1'b0;
			pend_write_reg <= 1'b0;
			pend_addr_reg  <= 8'h00;
			hreadyout_reg  <= 1'b1;
			hresp_reg      <= 1'b0;
		end else begin
			pend_reg       <= taken;
			hreadyout_reg  <= !taken;
			if (taken) begin
				pend_write_reg <= hwrite;
				pend_addr_reg  <= haddr[7:0];
			end
		end
	end

	always_comb begin
		xtal_ctrl_rd         = '0;
		xtal_ctrl_rd.speedup = xtal_ctrl_reg.speedup;
		xtal_ctrl_rd.stable  = stable_reg;
		xtal_ctrl_rd.enable  = xtal_ctrl_reg.enable;
	end

	// Unmapped offsets read as zero and ignore writes; the answer is always OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (rd_now) begin
			case (pend_addr_reg)
				osc_pkg::CLK_CTRL_OFF:  hrdata_reg <= {24'h00_0000, clk_ctrl_reg};
				osc_pkg::XTAL_CTRL_OFF: hrdata_reg <= {24'h00_0000, xtal_ctrl_rd};
				osc_pkg::PIN_OFF:  hrdata_reg <= {30'h0000_0000, pin_reg};
				osc_pkg::SU_OFF:   hrdata_reg <= {16'h0000, su_cnt_reg};
				osc_pkg::LP_OFF:   hrdata_reg <= {16'h0000, lp_cnt_reg};
				default:           hrdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// System clock control register
	// ----------------------------------------------------------------
	always_comb begin
		clk_ctrl_next     = osc_pkg::osc_clk_ctrl_s'(hwdata[7:0]);
		clk_ctrl_next.rsv = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_ctrl_reg <= osc_pkg::osc_clk_ctrl_s'(osc_pkg::CLK_CTRL_RST);
		end else if (wr_clk_ctrl) begin
			clk_ctrl_reg <= clk_ctrl_next;
		end
	end

	// ----------------------------------------------------------------
	// Slow crystal control, pin sharing and start-up counts
	// ----------------------------------------------------------------
	// The crystal drives the system clock when the field selects slow and the crystal is picked.
	assign locked = (clk_ctrl_reg.clk_sel == osc_pkg::SEL_SLOW)
		&& (clk_ctrl_reg.slow_src == osc_pkg::SLOW_SRC_XTAL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xtal_ctrl_reg <= '0;
		end else if (wr_xtal_ctrl) begin
			xtal_ctrl_reg.enable <= hwdata[0];
			if (!locked) begin
				xtal_ctrl_reg.speedup <= hwdata[2];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_reg <= osc_pkg::PIN_RST;
		end else if (wr_pin) begin
			pin_reg <= hwdata[1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			su_cnt_reg <= osc_pkg::SU_CNT_RST;
			lp_cnt_reg <= osc_pkg::LP_CNT_RST;
		end else begin
			if (wr_su) begin
				su_cnt_reg <= hwdata[15:0];
			end
			if (wr_lp) begin
				lp_cnt_reg <= hwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Slow crystal start-up
	// ----------------------------------------------------------------
	// A change of mode during start-up takes the new limit at once, and stability,
	// once reached, survives a later change of mode.
	assign limit = xtal_ctrl_reg.speedup ? su_cnt_reg : lp_cnt_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xstate_reg <= osc_pkg::XS_OFF;
			cnt_reg    <= 16'h0000;
			stable_reg <= 1'b0;
		end else begin
			case (xstate_reg)
				osc_pkg::XS_OFF: begin
					cnt_reg    <= 16'h0000;
					stable_reg <= 1'b0;
					if (xtal_ctrl_reg.enable) begin
						xstate_reg <= osc_pkg::XS_START;
					end
				end
				osc_pkg::XS_START: begin
					if (!xtal_ctrl_reg.enable) begin
						xstate_reg <= osc_pkg::XS_OFF;
					end else if (slow_xtal_tick) begin
						if (cnt_reg + 16'h0001 >= limit) begin
							xstate_reg <= osc_pkg::XS_STABLE;
							stable_reg <= 1'b1;
						end else begin
							cnt_reg <= cnt_reg + 16'h0001;
						end
					end
				end
				osc_pkg::XS_STABLE: begin
					if (!xtal_ctrl_reg.enable) begin
						xstate_reg <= osc_pkg::XS_OFF;
						stable_reg <= 1'b0;
					end
				end
				default: begin
					xstate_reg <= osc_pkg::XS_OFF;
					stable_reg <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sleep and idle
	// ----------------------------------------------------------------
	// A wake in the same cycle as a halt wins, so the core is never left stopped by a race.
	always_comb begin
		asleep_next = asleep_reg;
		if (wake_req) begin
			asleep_next = 1'b0;
		end else if (halt_req) begin
			asleep_next = 1'b1;
		end
	end

	logic sys_run_reg;
	logic fast_run_reg;
	logic slow_run_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			asleep_reg   <= 1'b0;
			sys_run_reg  <= 1'b1;
			fast_run_reg <= 1'b1;
			slow_run_reg <= 1'b1;
		end else begin
			asleep_reg   <= asleep_next;
			sys_run_reg  <= !asleep_next;
			fast_run_reg <= !asleep_next || clk_ctrl_reg.fast_idle_en;
			slow_run_reg <= !asleep_next || clk_ctrl_reg.slow_idle_en;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hrdata                = hrdata_reg;
	assign hreadyout             = hreadyout_reg;
	assign hresp                 = hresp_reg;
	assign sysclk_select_field   = clk_ctrl_reg.clk_sel;
	assign fast_source_sel       = clk_ctrl_reg.fast_src;
	assign slow_source_sel       = clk_ctrl_reg.slow_src;
	assign sys_clk_run           = sys_run_reg;
	assign fast_osc_run          = fast_run_reg;
	assign slow_osc_run          = slow_run_reg;
	assign slow_crystal_enable   = xtal_ctrl_reg.enable;
	assign slow_crystal_speedup  = xtal_ctrl_reg.speedup;
	assign slow_crystal_stable   = stable_reg;
	assign slow_xtal_in_pin_osc  = pin_reg[0];
	assign slow_xtal_out_pin_osc = pin_reg[1];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_bus_wait_state: assert property (taken |=> !hreadyout ##1 hreadyout)
		else $error("bus answer not after one wait state");
	a_fast_src_write: assert property (wr_clk_ctrl |=>
		fast_source_sel == $past(hwdata[3]))
		else $error("fast source select not written");
	a_slow_src_write: assert property (wr_clk_ctrl |=>
		slow_source_sel == $past(hwdata[2]))
		else $error("slow source select not written");
	a_clk_sel_write: assert property (wr_clk_ctrl |=>
		sysclk_select_field == $past(hwdata[7:5]))
		else $error("clock select field not written");
	a_mode_lock_held: assert property (locked |=> $stable(slow_crystal_speedup))
		else $error("crystal mode changed while driving system clock");
	a_mode_write_free: assert property (wr_xtal_ctrl && !locked |=>
		slow_crystal_speedup == $past(hwdata[2]))
		else $error("crystal mode not written while unlocked");
	a_stable_needs_en: assert property ($rose(slow_crystal_stable) |->
		$past(slow_crystal_enable) && $past(slow_xtal_tick))
		else $error("crystal stable without enable and tick");
	a_stable_count: assert property ($rose(slow_crystal_stable) |->
		$past(cnt_reg) + 16'h0001 >= $past(limit))
		else $error("crystal stable before start-up count");
	a_lp_keeps_run: assert property (slow_crystal_stable && slow_crystal_enable
		&& !wr_xtal_ctrl |=> slow_crystal_stable)
		else $error("crystal lost stability without disable");
	a_halt_stops_clk: assert property (halt_req && !wake_req |=> !sys_clk_run)
		else $error("system clock not stopped on halt");
	a_pin_share_write: assert property (wr_pin |=>
		{slow_xtal_out_pin_osc, slow_xtal_in_pin_osc} == $past(hwdata[1:0]))
		else $error("pin sharing bits not written");

	c_crystal_stable: cover property ($rose(slow_crystal_stable));
	c_mode_locked:    cover property (locked && wr_xtal_ctrl);
	c_sleep_wake:     cover property (!sys_clk_run ##[1:20] sys_clk_run);
	c_lp_after_start: cover property (slow_crystal_stable && $fell(slow_crystal_speedup));

endmodule : osc_ctrl

//--- osc_xtal_model.sv
// Behavioural model of the slow crystal cell that sits beside the clock control block.
// Assumes hclk is far faster than the crystal, so one crystal cycle becomes one tick pulse.
`timescale 1ns/1ps
module osc_xtal_model #(
	parameter int PERIOD = 4
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic enable,
	input  wire logic in_pin_osc,
	input  wire logic out_pin_osc,
	output logic      tick
);
	// ----------------------------------------------------------------
	// Oscillation
	// ----------------------------------------------------------------
	logic [7:0] phase_reg;

	// A crystal with a pin left to general I/O cannot swing, so no ticks come out.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= 8'h00;
			tick      <= 1'b0;
		end else if (!(enable && in_pin_osc && out_pin_osc)) begin
			phase_reg <= 8'h00;
			tick      <= 1'b0;
		end else begin
			phase_reg <= (phase_reg == 8'(PERIOD - 1)) ? 8'h00 : phase_reg + 8'h01;
			tick      <= (phase_reg == 8'(PERIOD - 2));
		end
	end
endmodule : osc_xtal_model

//--- oscillator_source_control_test.sv
// Self-checking bench for the oscillator source control block.
// Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module oscillator_source_control_test;
	logic        hclk, hresetn, hsel, hwrite, hready, halt_req, wake_req;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, sysclk_select_field;
	logic        hreadyout, hresp, fast_source_sel, slow_source_sel, sys_clk_run;
	logic        fast_osc_run, slow_osc_run, slow_crystal_enable, slow_crystal_speedup;
	logic        slow_crystal_stable, slow_xtal_in_pin_osc, slow_xtal_out_pin_osc, tick;
	logic [7:0]  d;
	int          err_count, checked, ticks, n;

	assign hready = hreadyout;

	osc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req),
		.wake_req(wake_req), .slow_xtal_tick(tick), .sysclk_select_field(sysclk_select_field),
		.fast_source_sel(fast_source_sel), .slow_source_sel(slow_source_sel),
		.sys_clk_run(sys_clk_run), .fast_osc_run(fast_osc_run), .slow_osc_run(slow_osc_run),
		.slow_crystal_enable(slow_crystal_enable), .slow_crystal_speedup(slow_crystal_speedup),
		.slow_crystal_stable(slow_crystal_stable), .slow_xtal_in_pin_osc(slow_xtal_in_pin_osc),
		.slow_xtal_out_pin_osc(slow_xtal_out_pin_osc));

	osc_xtal_model #(.PERIOD(4)) xtal (.hclk(hclk), .hresetn(hresetn),
		.enable(slow_crystal_enable), .in_pin_osc(slow_xtal_in_pin_osc),
		.out_pin_osc(slow_xtal_out_pin_osc), .tick(tick));

	// ----------------------------------------------------------------
	// Clock, tick count and watchdog
	// ----------------------------------------------------------------
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (tick === 1'b1) ticks++;
	end

	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// The master never assumes the wait-state count; only the watchdog ends a stuck wait.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= osc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize  <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
		#1;
	endtask : bus

	task automatic pulse(input logic h);
		@(posedge hclk);
		if (h) halt_req <= 1'b1;
		else wake_req <= 1'b1;
		@(posedge hclk);
		halt_req <= 1'b0;
		wake_req <= 1'b0;
		#1;
	endtask : pulse

	task automatic start_xtal(input logic [31:0] ctrl, input int limit);
		ticks = 0;
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, ctrl);
		for (n = 0; n < 400 && slow_crystal_stable !== 1'b1; n++) @(posedge hclk);
		#1;
		chk(32'(ticks), 32'(limit));
	endtask : start_xtal

	function automatic logic [7:0] clk_ctrl_exp(input logic [7:0] v);
		return v & 8'hef;
	endfunction : clk_ctrl_exp

	task automatic tally_and_finish();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{hsel, hwrite, halt_req, wake_req} = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		err_count = 0;
		checked = 0;
		ticks = 0;
		hresetn = 1'b0;
		void'($urandom(32'h7338aa9e));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk({sysclk_select_field, fast_source_sel, sys_clk_run}, 5'h01);
		bus(1'b0, osc_pkg::SU_OFF, 32'h0);
		chk(rd, 32'h00000400);
		bus(1'b0, osc_pkg::LP_OFF, 32'h0);
		chk(rd, 32'h00004000);
		bus(1'b1, 8'h40, 32'hffffffff);
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		// Twelve clock selections, eight fixed and four random, each followed by a halt and a wake.
		for (int i = 0; i < 12; i++) begin
			d = (i < 8) ? {i[2:0], 5'(i * 5)} : 8'($urandom);
			bus(1'b1, osc_pkg::CLK_CTRL_OFF, {$urandom, d} >> 32);
			bus(1'b1, osc_pkg::CLK_CTRL_OFF, {24'h0, d});
			bus(1'b0, osc_pkg::CLK_CTRL_OFF, 32'h0);
			chk(rd, {24'h0, clk_ctrl_exp(d)});
			chk({29'h0, sysclk_select_field}, {29'h0, d[7:5]});
			chk({31'h0, fast_source_sel}, {31'h0, d[3]});
			chk({31'h0, slow_source_sel}, {31'h0, d[2]});
			pulse(1'b1);
			chk({sys_clk_run, fast_osc_run, slow_osc_run}, {1'b0, d[1:0]});
			pulse(1'b0);
			chk({sys_clk_run, fast_osc_run, slow_osc_run}, 3'h7);
		end
		bus(1'b1, osc_pkg::CLK_CTRL_OFF, 32'h0);
		bus(1'b1, osc_pkg::SU_OFF, 32'h4);
		bus(1'b1, osc_pkg::LP_OFF, 32'h6);
		// With its pins left to general I/O the crystal cannot swing, so it never settles.
		ticks = 0;
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, 32'h5);
		repeat (60) @(posedge hclk);
		#1;
		chk(32'(ticks), 32'h0);
		chk({31'h0, slow_crystal_stable}, 32'h0);
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, 32'h0);
		bus(1'b1, osc_pkg::PIN_OFF, 32'h3);
		chk({slow_xtal_out_pin_osc, slow_xtal_in_pin_osc}, 2'h3);
		start_xtal(32'h5, 4);
		chk({slow_crystal_speedup, slow_crystal_enable}, 2'h3);
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, 32'h1);
		repeat (10) @(posedge hclk);
		#1;
		chk({slow_crystal_speedup, slow_crystal_stable}, 2'h1);
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, 32'h0);
		bus(1'b0, osc_pkg::XTAL_CTRL_OFF, 32'h0);
		chk(rd, 32'h0);
		start_xtal(32'h1, 6);
		chk({29'h0, slow_crystal_speedup, slow_crystal_stable, slow_crystal_enable}, 32'h3);
		// While the crystal drives the system clock the mode bit must not move.
		bus(1'b1, osc_pkg::CLK_CTRL_OFF, 32'he4);
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, 32'h5);
		bus(1'b0, osc_pkg::XTAL_CTRL_OFF, 32'h0);
		chk(rd, 32'h3);
		bus(1'b1, osc_pkg::CLK_CTRL_OFF, 32'h04);
		bus(1'b1, osc_pkg::XTAL_CTRL_OFF, 32'h5);
		chk({31'h0, slow_crystal_speedup}, 32'h1);
		tally_and_finish();
	end
endmodule : oscillator_source_control_test
